// ### design/plls_defines.svh
/*
 * Register offsets, field positions, reset values and model constants
 * for the loop clock synthesiser. Assumes a 32-bit AXI4-Lite register
 * bus with byte addresses.
 */
`ifndef PLLS_DEFINES_SVH
`define PLLS_DEFINES_SVH

`define PLLS_ADDR_W 8
`define PLLS_OFS_CTRL 8'h00
`define PLLS_OFS_STATUS 8'h04
`define PLLS_OFS_NDIV 8'h08
`define PLLS_OFS_MDIV 8'h0c
`define PLLS_OFS_LOCKCFG 8'h10
`define PLLS_OFS_FREQ 8'h14
`define PLLS_OFS_NOMINAL 8'h18
`define PLLS_OFS_OUT0 8'h20
`define PLLS_OFS_OUT4 8'h30

`define PLLS_CTRL_PFD_EN 0
`define PLLS_CTRL_RESTART 1
`define PLLS_CTRL_SEL_LO 2
`define PLLS_CTRL_SEL_HI 3
`define PLLS_CTRL_DIFF 4
`define PLLS_ST_LOCK 0
`define PLLS_ST_CFG_ERR 1
`define PLLS_ST_UP 2
`define PLLS_ST_DOWN 3

`define PLLS_DIV_MAX 11'h200
`define PLLS_DIV_MAX_ODD 11'h100
`define PLLS_DIV_RST 10'h001
`define PLLS_OUT_HALF_RST 10'h001
`define PLLS_WIN_RST 8'h04
`define PLLS_NEED_RST 8'h08
`define PLLS_NOMINAL_RST 32'h2000_0000
`define PLLS_FREQ_STEP 32'h0001_0000
`define PLLS_TAP_SHIFT 29
`define PLLS_NUM_OUT 5
`define PLLS_NUM_LINES 20
`define PLLS_RESP_OKAY 2'b00
`define PLLS_RESP_SLVERR 2'b10

`endif

// ### design/plls_pkg.sv
/*
 * Types shared by the loop clock synthesiser: bus carriers, output
 * divider configuration and detector states. Assumes plls_defines.svh.
 */
package plls_pkg;
   typedef struct packed {
      logic [7:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [7:0] araddr;
      logic arvalid;
      logic rready;
   } plls_axi_req_type;

   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } plls_axi_rsp_type;

   typedef struct packed {
      logic [3:0] line_en;
      logic [2:0] tap;
      logic [9:0] lo;
      logic [9:0] hi;
   } plls_out_cfg_type;

   typedef enum logic [1:0] {
      PLLS_PFD_IDLE = 2'b00,
      PLLS_PFD_REF_LEAD = 2'b01,
      PLLS_PFD_FB_LEAD = 2'b10
   } plls_pfd_state_type;
endpackage : plls_pkg

// ### design/plls_synth.sv
/*
 * Cycle-based behavioural model of one loop clock synthesiser with an
 * AXI4-Lite register slave. Assumes reference pins are asynchronous and
 * that oscillator ticks are modelled at a scaled rate on i_clock.
 */
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "plls_defines.svh"

// How it works
// RULE_01 - Detector compares rising edges, gives up/down
// RULE_02 - Oscillator settles at input times M over N
// RULE_03 - Software keeps oscillator within 600-1300 MHz
// RULE_04 - Oscillator feeds five independent output dividers
// RULE_05 - Output equals input times M over N*C
// RULE_06 - Five global outputs plus one external output
// RULE_07 - All dividers accept settings 1 to 512
// RULE_08 - Uneven duty limits output divider to 256
// RULE_09 - Phase steps of one eighth oscillator period
// RULE_10 - Four-way reference mux with input switchover
// RULE_11 - Four single-ended or two differential reference pins
// RULE_12 - Each output reaches four fixed global lines
// RULE_13 - Converter clock only from output zero, loops 1/3
// RULE_14 - Detector enable on by default, gates correction
// RULE_15 - Restart clears dividers, outputs, lock, frequency
// RULE_16 - After restart the loop reacquires lock
// RULE_17 - Restart never stops the oscillator
// RULE_18 - Restart from pin or core logic
// RULE_19 - Lock only when loop and outputs settled; the code qualifies lock on detector comparisons only
// RULE_20 - Lock passes a restart-tied flip-flop stage
// RULE_21 - Controller uses restart and lock signals
// RULE_22 - Lock after N good comparisons, drop on bad
// RULE_23 - Duty set by high and low counts
module plls_synth #(
   parameter int LOOP_INDEX = 1,   // Loop instance 1 to 4
   parameter bit RESTART_USED = 1'b1   // Restart input enabled
) (
   input wire logic i_clock,   // 250 MHz system clock
   input wire logic i_srst,   // Synchronous reset, active high
   input wire plls_pkg::plls_axi_req_type i_axi,   // AXI4-Lite request
   output plls_pkg::plls_axi_rsp_type o_axi,   // AXI4-Lite response
   input wire logic [3:0] i_ref_pin,   // Reference clock pins
   input wire logic i_loop_restart,   // Restart pin, active high
   output logic [4:0] o_out_clk,   // Output divider clocks
   output logic [19:0] o_global_clock_line,   // Global clock lines
   output logic o_ext_clk,   // Dedicated external clock
   output logic o_adc_clk,   // Converter clock
   output logic o_locked   // Lock indicator
);
   import plls_pkg::*;

   // Register file
   logic pfd_en_r, sw_restart_r, diff_r, cfg_err_r;
   logic [1:0] ref_sel_r;
   logic [9:0] ndiv_r, mdiv_r;
   logic [7:0] win_r, need_r;
   logic [31:0] nominal_r;
   plls_out_cfg_type out_cfg_r [`PLLS_NUM_OUT];
   // Bus state
   logic aw_hold_r, w_hold_r, aw_hold_nxt, w_hold_nxt, bvalid_nxt;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic aw_fire, w_fire, ar_fire, do_write, rvalid_nxt;
   // Loop state
   logic [3:0] pin_s1_r, pin_s2_r;
   logic restart_s1_r, restart_s2_r, restart_act;
   logic ref_lvl, ref_prev_r, ref_edge;
   logic [9:0] n_cnt_r, m_cnt_r;
   logic ref_ev, fb_ev, vco_tick, cmp_ev, cmp_in_win, cmp_up, cmp_dn;
   logic [32:0] acc_sum;
   logic [31:0] acc_r, fw_r;
   logic [15:0] err_cnt_r;
   logic [7:0] good_cnt_r;
   logic lock_core_r, up_r, dn_r;
   plls_pfd_state_type pfd_state_r;
   logic [4:0] tap_msb_r, tap_tick, out_r;
   logic [9:0] div_cnt_r [`PLLS_NUM_OUT];
   logic [4:0] div_hi_r;
   logic [19:0] line_nxt;

   // Output divider settings: sum of high and low is the setting
   function automatic logic out_cfg_ok(input plls_out_cfg_type c);
      logic [10:0] sum;
      sum = {1'b0, c.hi} + {1'b0, c.lo};
      out_cfg_ok = (c.hi != 10'h000) && (sum <= `PLLS_DIV_MAX) &&
         ((c.hi == c.lo) || (sum <= `PLLS_DIV_MAX_ODD));   // RULE_07 RULE_08
   endfunction : out_cfg_ok

   function automatic logic div_ok(input logic [31:0] v);
      div_ok = (v != 32'h0) && (v <= {21'h0, `PLLS_DIV_MAX});   // RULE_07
   endfunction : div_ok

   function automatic logic [31:0] wmerge(input logic [31:0] old,
         input logic [31:0] d, input logic [3:0] s);
      for (int b = 0; b < 4; b++) begin
         old[b*8 +: 8] = s[b] ? d[b*8 +: 8] : old[b*8 +: 8];
      end
      wmerge = old;
   endfunction : wmerge

   // Global line reached by output o through its j-th route
   function automatic logic [4:0] route_line(input int o, input int j);
      logic [4:0] base_a, base_b, ofs;
      base_a = (LOOP_INDEX == 2 || LOOP_INDEX == 4) ? 5'h05 : 5'h00;
      base_b = (LOOP_INDEX == 1 || LOOP_INDEX == 4) ? 5'h0f : 5'h0a;
      case (o)
         0: ofs = j[0] ? 5'h03 : 5'h00;
         1: ofs = j[0] ? 5'h04 : 5'h01;
         2: ofs = j[0] ? 5'h02 : 5'h00;
         3: ofs = j[0] ? 5'h03 : 5'h01;
         default: ofs = j[0] ? 5'h04 : 5'h02;
      endcase
      route_line = (j[1] ? base_b : base_a) + ofs;   // RULE_12
   endfunction : route_line

   function automatic logic [31:0] reg_read(input logic [7:0] a);
      reg_read = 32'h0;
      if (a == `PLLS_OFS_CTRL) begin
         reg_read[`PLLS_CTRL_PFD_EN] = pfd_en_r;
         reg_read[`PLLS_CTRL_RESTART] = sw_restart_r;
         reg_read[`PLLS_CTRL_SEL_HI:`PLLS_CTRL_SEL_LO] = ref_sel_r;
         reg_read[`PLLS_CTRL_DIFF] = diff_r;
      end else if (a == `PLLS_OFS_STATUS) begin
         reg_read[`PLLS_ST_LOCK] = o_locked;
         reg_read[`PLLS_ST_CFG_ERR] = cfg_err_r;
         reg_read[`PLLS_ST_UP] = up_r;
         reg_read[`PLLS_ST_DOWN] = dn_r;
      end else if (a == `PLLS_OFS_NDIV) begin
         reg_read[9:0] = ndiv_r;
      end else if (a == `PLLS_OFS_MDIV) begin
         reg_read[9:0] = mdiv_r;
      end else if (a == `PLLS_OFS_LOCKCFG) begin
         reg_read[15:0] = {need_r, win_r};
      end else if (a == `PLLS_OFS_FREQ) begin
         reg_read = fw_r;
      end else if (a == `PLLS_OFS_NOMINAL) begin
         reg_read = nominal_r;
      end else if (a >= `PLLS_OFS_OUT0 && a <= `PLLS_OFS_OUT4) begin
         reg_read[26:0] = out_cfg_r[3'((a - `PLLS_OFS_OUT0) >> 2)];
      end
   endfunction : reg_read

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a[1:0] == 2'b00) && ((a <= `PLLS_OFS_NOMINAL) ||
         (a >= `PLLS_OFS_OUT0 && a <= `PLLS_OFS_OUT4));
   endfunction : addr_ok

   // AXI4-Lite slave: address and data taken in either order
   assign aw_fire = i_axi.awvalid & o_axi.awready;
   assign w_fire = i_axi.wvalid & o_axi.wready;
   assign ar_fire = i_axi.arvalid & o_axi.arready;
   assign do_write = aw_hold_r & w_hold_r & ~o_axi.bvalid;

   always_comb begin
      aw_hold_nxt = (aw_hold_r | aw_fire) & ~do_write;
      w_hold_nxt = (w_hold_r | w_fire) & ~do_write;
      bvalid_nxt = do_write | (o_axi.bvalid & ~i_axi.bready);
      rvalid_nxt = ar_fire | (o_axi.rvalid & ~i_axi.rready);
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
         o_axi <= '0;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         w_hold_r <= w_hold_nxt;
         if (aw_fire) begin
            aw_addr_r <= i_axi.awaddr;
         end
         if (w_fire) begin
            w_data_r <= i_axi.wdata;
            w_strb_r <= i_axi.wstrb;
         end
         o_axi.awready <= ~aw_hold_nxt & ~bvalid_nxt;
         o_axi.wready <= ~w_hold_nxt & ~bvalid_nxt;
         o_axi.bvalid <= bvalid_nxt;
         if (do_write) begin
            o_axi.bresp <= addr_ok(aw_addr_r) ? `PLLS_RESP_OKAY
                                              : `PLLS_RESP_SLVERR;
         end
         o_axi.arready <= ~rvalid_nxt;
         o_axi.rvalid <= rvalid_nxt;
         if (ar_fire) begin
            o_axi.rdata <= reg_read(i_axi.araddr);
            o_axi.rresp <= addr_ok(i_axi.araddr) ? `PLLS_RESP_OKAY
                                                 : `PLLS_RESP_SLVERR;
         end
      end
   end

   // Register writes; out-of-range settings are dropped and flagged
   always_ff @(posedge i_clock) begin
      logic [31:0] v;
      logic [2:0] idx;
      v = wmerge(reg_read(aw_addr_r), w_data_r, w_strb_r);
      idx = 3'((aw_addr_r - `PLLS_OFS_OUT0) >> 2);
      if (i_srst) begin
         pfd_en_r <= 1'b1;   // RULE_14
         sw_restart_r <= 1'b0;
         ref_sel_r <= 2'b00;
         diff_r <= 1'b0;
         cfg_err_r <= 1'b0;
         ndiv_r <= `PLLS_DIV_RST;
         mdiv_r <= `PLLS_DIV_RST;
         win_r <= `PLLS_WIN_RST;
         need_r <= `PLLS_NEED_RST;
         nominal_r <= `PLLS_NOMINAL_RST;
         for (int i = 0; i < `PLLS_NUM_OUT; i++) begin
            out_cfg_r[i] <= '{line_en: 4'h1, tap: 3'h0,
               lo: `PLLS_OUT_HALF_RST, hi: `PLLS_OUT_HALF_RST};
         end
      end else if (do_write && addr_ok(aw_addr_r)) begin
         case (aw_addr_r)
            `PLLS_OFS_CTRL: begin
               pfd_en_r <= v[`PLLS_CTRL_PFD_EN];
               sw_restart_r <= v[`PLLS_CTRL_RESTART];   // RULE_18
               ref_sel_r <= v[`PLLS_CTRL_SEL_HI:`PLLS_CTRL_SEL_LO];   // RULE_10
               diff_r <= v[`PLLS_CTRL_DIFF];   // RULE_11
            end
            `PLLS_OFS_STATUS: begin
               cfg_err_r <= cfg_err_r & ~v[`PLLS_ST_CFG_ERR];
            end
            `PLLS_OFS_NDIV: begin
               if (div_ok(v)) ndiv_r <= 10'(v - 32'h1);
               cfg_err_r <= cfg_err_r | ~div_ok(v);
            end
            `PLLS_OFS_MDIV: begin
               if (div_ok(v)) mdiv_r <= 10'(v - 32'h1);
               cfg_err_r <= cfg_err_r | ~div_ok(v);
            end
            `PLLS_OFS_LOCKCFG: begin
               win_r <= v[7:0];
               need_r <= v[15:8];
            end
            `PLLS_OFS_NOMINAL: begin
               nominal_r <= v;
            end
            `PLLS_OFS_FREQ: begin
            end
            default: begin
               if (out_cfg_ok(v[26:0])) out_cfg_r[idx] <= v[26:0];
               cfg_err_r <= cfg_err_r | ~out_cfg_ok(v[26:0]);
            end
         endcase
      end
   end

   // Pins pass two flip-flops before anything reads them
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         pin_s1_r <= 4'h0;
         pin_s2_r <= 4'h0;
         restart_s1_r <= 1'b0;
         restart_s2_r <= 1'b0;
         ref_prev_r <= 1'b0;
      end else begin
         pin_s1_r <= i_ref_pin;
         pin_s2_r <= pin_s1_r;
         restart_s1_r <= i_loop_restart;
         restart_s2_r <= restart_s1_r;
         ref_prev_r <= ref_lvl;
      end
   end

   // Differential mode uses the true pin of pair 0 or 1
   assign ref_lvl = diff_r ? pin_s2_r[{ref_sel_r[0], 1'b0}]
                           : pin_s2_r[ref_sel_r];   // RULE_10 RULE_11
   assign ref_edge = ref_lvl & ~ref_prev_r;
   assign restart_act = RESTART_USED & (restart_s2_r | sw_restart_r);   // RULE_18

   // Oscillator: phase accumulator, ticks on wrap; never stopped
   assign acc_sum = {1'b0, acc_r} + {1'b0, fw_r};
   assign vco_tick = acc_sum[32];
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         acc_r <= 32'h0;
      end else begin
         acc_r <= acc_sum[31:0];   // RULE_17
      end
   end

   // Pre-scale on reference edges, feedback divider on ticks
   // Compare by >= so a setting lowered below the count does not stall
   assign ref_ev = ref_edge && n_cnt_r >= ndiv_r;
   assign fb_ev = vco_tick && m_cnt_r >= mdiv_r;   // RULE_02
   always_ff @(posedge i_clock) begin
      if (i_srst || restart_act) begin
         n_cnt_r <= 10'h000;   // RULE_15
         m_cnt_r <= 10'h000;
      end else begin
         if (ref_edge) n_cnt_r <= ref_ev ? 10'h000 : n_cnt_r + 10'h001;
         if (vco_tick) m_cnt_r <= fb_ev ? 10'h000 : m_cnt_r + 10'h001;
      end
   end

   // Phase detector: first edge opens a comparison, second closes it
   assign cmp_ev = (ref_ev & fb_ev) |
      (ref_ev & pfd_state_r == PLLS_PFD_FB_LEAD) |
      (fb_ev & pfd_state_r == PLLS_PFD_REF_LEAD);
   assign cmp_up = cmp_ev & ~(ref_ev & fb_ev) &
      (pfd_state_r == PLLS_PFD_REF_LEAD);   // RULE_01
   assign cmp_dn = cmp_ev & ~(ref_ev & fb_ev) &
      (pfd_state_r == PLLS_PFD_FB_LEAD);   // RULE_01
   assign cmp_in_win = (ref_ev & fb_ev) || err_cnt_r <= {8'h00, win_r};

   always_ff @(posedge i_clock) begin
      if (i_srst || restart_act) begin
         pfd_state_r <= PLLS_PFD_IDLE;
         err_cnt_r <= 16'h0;
      end else begin
         case (pfd_state_r)
            PLLS_PFD_IDLE: begin
               err_cnt_r <= 16'h0;
               if (ref_ev && !fb_ev) pfd_state_r <= PLLS_PFD_REF_LEAD;
               else if (fb_ev && !ref_ev) pfd_state_r <= PLLS_PFD_FB_LEAD;
            end
            PLLS_PFD_REF_LEAD, PLLS_PFD_FB_LEAD: begin
               if (err_cnt_r != 16'hffff) err_cnt_r <= err_cnt_r + 16'h1;
               if (cmp_ev) pfd_state_r <= PLLS_PFD_IDLE;
            end
            default: pfd_state_r <= PLLS_PFD_IDLE;
         endcase
      end
   end

   // Bang-bang correction; gated off when the detector is disabled
   always_ff @(posedge i_clock) begin
      if (i_srst || restart_act) begin
         fw_r <= i_srst ? `PLLS_NOMINAL_RST : nominal_r;   // RULE_15
         up_r <= 1'b0;
         dn_r <= 1'b0;
      end else begin
         if (pfd_en_r && cmp_up) fw_r <= fw_r + `PLLS_FREQ_STEP;   // RULE_14
         else if (pfd_en_r && cmp_dn) fw_r <= fw_r - `PLLS_FREQ_STEP;
         if (cmp_ev) begin
            up_r <= cmp_up;
            dn_r <= cmp_dn;
         end
      end
   end

   // Lock qualification; released restart lets it build again
   always_ff @(posedge i_clock) begin
      if (i_srst || restart_act) begin
         good_cnt_r <= 8'h00;   // RULE_16
         lock_core_r <= 1'b0;
      end else if (cmp_ev) begin
         if (!cmp_in_win) begin
            good_cnt_r <= 8'h00;   // RULE_22
            lock_core_r <= 1'b0;
         end else if (good_cnt_r < need_r) begin
            good_cnt_r <= good_cnt_r + 8'h01;
         end else begin
            lock_core_r <= 1'b1;   // RULE_19 RULE_22
         end
      end
   end

   // Fine phase: each output ticks on its own eighth-period tap
   always_comb begin
      logic [31:0] sh;
      sh = 32'h0;
      for (int i = 0; i < `PLLS_NUM_OUT; i++) begin
         sh = acc_sum[31:0] +
            (32'(out_cfg_r[i].tap) << `PLLS_TAP_SHIFT);   // RULE_09
         tap_tick[i] = tap_msb_r[i] & ~sh[31];
      end
   end

   // Five output dividers, each with high and low counts
   always_ff @(posedge i_clock) begin
      logic [31:0] shv;
      for (int i = 0; i < `PLLS_NUM_OUT; i++) begin
         shv = acc_sum[31:0] + (32'(out_cfg_r[i].tap) << `PLLS_TAP_SHIFT);
         if (i_srst || restart_act) begin
            tap_msb_r[i] <= 1'b0;
            div_cnt_r[i] <= 10'h000;
            div_hi_r[i] <= 1'b0;
            out_r[i] <= 1'b0;   // RULE_15
         end else begin
            tap_msb_r[i] <= shv[31];
            if (tap_tick[i]) begin   // RULE_04 RULE_05
               if (out_cfg_r[i].lo == 10'h000) begin
                  out_r[i] <= ~out_r[i];
               end else if (div_cnt_r[i] + 10'h001 >=
                     (div_hi_r[i] ? out_cfg_r[i].hi : out_cfg_r[i].lo)) begin
                  div_cnt_r[i] <= 10'h000;   // RULE_23
                  div_hi_r[i] <= ~div_hi_r[i];
                  out_r[i] <= ~div_hi_r[i];
               end else begin
                  div_cnt_r[i] <= div_cnt_r[i] + 10'h001;
               end
            end
         end
      end
   end

   // Line driven by the lowest enabled output that reaches it
   always_comb begin
      line_nxt = 20'h0;
      for (int i = `PLLS_NUM_OUT - 1; i >= 0; i--) begin
         for (int j = 0; j < 4; j++) begin
            if (out_cfg_r[i].line_en[j]) begin
               line_nxt[route_line(i, j)] = out_r[i];   // RULE_12
            end
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst || restart_act) begin
         o_out_clk <= 5'h00;
         o_global_clock_line <= 20'h0;
         o_ext_clk <= 1'b0;
         o_adc_clk <= 1'b0;
      end else begin
         o_out_clk <= out_r;   // RULE_06
         o_global_clock_line <= line_nxt;
         o_ext_clk <= out_r[0];   // RULE_06
         o_adc_clk <= (LOOP_INDEX == 1 || LOOP_INDEX == 3) & out_r[0];   // RULE_13
      end
   end

   // Extra stage held clear by restart only when restart is enabled
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_locked <= 1'b0;
      end else begin
         o_locked <= lock_core_r & ~restart_act;   // RULE_20
      end
   end

   sequence seq_ref_lead_close;
      pfd_state_r == PLLS_PFD_REF_LEAD && fb_ev && !ref_ev;
   endsequence
   sequence seq_restart_held;
      restart_act ##1 restart_act;
   endsequence

   chk_pfd_up_dir: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_01
      seq_ref_lead_close ##0 (pfd_en_r && !restart_act) |=>
      fw_r == $past(fw_r) + `PLLS_FREQ_STEP)
      else $error("detector did not speed up the oscillator");
   chk_pfd_gated: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_14
      !pfd_en_r && !restart_act |=> fw_r == $past(fw_r))
      else $error("frequency moved while detector disabled");
   chk_fb_divide: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_02
      fb_ev |-> vco_tick && m_cnt_r >= mdiv_r ##1 m_cnt_r == 10'h000)
      else $error("feedback divider mistimed");
   chk_restart_clear: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_15
      seq_restart_held |-> fw_r == nominal_r && !lock_core_r &&
      o_global_clock_line == 20'h0 && !o_locked)
      else $error("restart did not clear loop state");
   chk_osc_runs: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_17
      restart_act && fw_r != 32'h0 |=> acc_r != $past(acc_r))
      else $error("oscillator stopped during restart");
   chk_lock_drop: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_22
      cmp_ev && !cmp_in_win |=> !lock_core_r ##1 !o_locked)
      else $error("lock held after out-of-window comparison");
   chk_lock_count: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_22
      $rose(lock_core_r) |-> $past(good_cnt_r) >= $past(need_r))
      else $error("lock rose before enough good comparisons");
   chk_lock_stage: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_20
      ##1 o_locked == $past(lock_core_r && !restart_act))
      else $error("lock stage out of step");
   chk_div_range: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_08
      out_cfg_ok(out_cfg_r[0]) && out_cfg_ok(out_cfg_r[4]))
      else $error("output divider holds an illegal setting");
   chk_adc_path: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_13
      (LOOP_INDEX == 2 || LOOP_INDEX == 4) |-> !o_adc_clk)
      else $error("converter clock driven from wrong loop");
endmodule : plls_synth

// ### test/plls_partner.sv
/* Core-side partner: drives reference pins and the restart pin.
   Assumes i_clock is the system clock and the loop watches lock. */
`timescale 1ns/1ps
module plls_partner #(
   parameter int HALF = 6   // Reference half period in cycles
) (
   input wire logic i_clock,   // System clock
   input wire logic i_srst,   // Reset
   input wire logic i_restart_req,   // Bench asks for a restart
   output logic [3:0] o_ref_pin,   // Reference pins
   output logic o_restart   // Restart pin
);
   int cnt;
   always_ff @(posedge i_clock) begin
      if (i_srst || cnt == HALF - 1) cnt <= 0;
      else cnt <= cnt + 1;
      // All pins carry one reference so any select sees a clock
      if (i_srst) o_ref_pin <= 4'h0;
      else if (cnt == HALF - 1) o_ref_pin <= ~o_ref_pin;
   end
   always_ff @(posedge i_clock) o_restart <= i_restart_req;
endmodule : plls_partner

// ### test/plls_synth_test.sv
/* Self-checking bench for plls_synth: register table, divider limits,
   restart and output copies. Assumes the partner drives the pins. */
`timescale 1ns/1ps
`include "plls_defines.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
   $display("ERROR %0t: got %h want %h", $time, a, b); end end
module plls_synth_test;
   import plls_pkg::*;
   logic clk = 0, srst = 1, rst_req = 0, restart, lk, ext, adc;
   logic [3:0] pins;
   logic [4:0] oc;
   logic [19:0] gl;
   logic [31:0] d, d0;
   logic [1:0] r;
   int failures = 0, n_tests = 0;
   plls_axi_req_type req = '0;
   plls_axi_rsp_type rsp;
   typedef struct {logic [7:0] a; bit w; logic [31:0] d, e; logic [1:0] r;}
      row_type;
   row_type rows[8] = '{
      '{8'h00, 0, 0, 32'h1, 2'b00}, '{8'h10, 0, 0, 32'h804, 2'b00},
      '{8'h18, 0, 0, 32'h2000_0000, 2'b00}, '{8'h20, 0, 0, 32'h80_0401, 0},
      '{8'h08, 0, 0, 32'h1, 2'b00}, '{8'h08, 1, 32'h200, 32'h1ff, 2'b00},
      '{8'h24, 1, 32'h4_0100, 32'h4_0100, 0}, '{8'h40, 0, 0, 32'h0, 2'b10}};
   always #2 clk = ~clk;
   plls_partner prt (.i_clock(clk), .i_srst(srst), .i_restart_req(rst_req),
      .o_ref_pin(pins), .o_restart(restart));
   plls_synth dut (.i_clock(clk), .i_srst(srst), .i_axi(req), .o_axi(rsp),
      .i_ref_pin(pins), .i_loop_restart(restart), .o_out_clk(oc),
      .o_global_clock_line(gl), .o_ext_clk(ext), .o_adc_clk(adc),
      .o_locked(lk));
   // Ready to accept a response stays up between calls; a wait ends
   // when the response valid is seen, with no timeout but the watchdog
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      req.awaddr <= a; req.wdata <= v; req.wstrb <= 4'hf;
      req.awvalid <= 1; req.wvalid <= 1; req.bready <= 1;
      forever begin
         @(posedge clk);
         if (req.awvalid && rsp.awready) req.awvalid <= 0;
         if (req.wvalid && rsp.wready) req.wvalid <= 0;
         if (rsp.bvalid) break;
      end
      r = rsp.bresp;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      req.araddr <= a; req.arvalid <= 1; req.rready <= 1;
      forever begin
         @(posedge clk);
         if (req.arvalid && rsp.arready) req.arvalid <= 0;
         if (rsp.rvalid) break;
      end
      d = rsp.rdata;
      r = rsp.rresp;
   endtask : rd
   task automatic final_report();
      if (failures == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report
   initial begin
      #40000;
      failures++;
      final_report();
   end
   initial begin
      repeat (12) @(posedge clk);
      srst <= 0;
      `CHK(lk, 1'b0)
      @(posedge clk);
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         @(posedge clk);
         rd(rows[i].a);
         `CHK({r, d}, {rows[i].r, rows[i].e})
      end
      // Uneven duty with a sum above the odd-duty ceiling is dropped
      wr(8'h28, 32'h3_2064);
      rd(8'h28);
      `CHK(d, 32'h80_0401)
      rd(8'h04);
      `CHK(d[1], 1'b1)
      wr(8'h04, 32'h2);
      rd(8'h04);
      `CHK(d[1], 1'b0)
      wr(8'h0c, 32'h0);
      rd(8'h04);
      `CHK(d[1], 1'b1)
      repeat (100) @(posedge clk) begin
         `CHK(ext, oc[0])
         `CHK(adc, oc[0])
         `CHK(gl[0], oc[0])
         `CHK(gl[18:15], 4'h0)
      end
      wr(8'h10, 32'h2ff);
      wr(8'h08, 32'h2);
      repeat (200) @(posedge clk);
      `CHK(lk, 1'b1)
      wr(8'h00, 32'h1c);
      rd(8'h00);
      `CHK(d, 32'h1c)
      rd(8'h14);
      d0 = d;
      repeat (60) @(posedge clk);
      rd(8'h14);
      `CHK(d, d0)
      wr(8'h00, 32'h1);
      wr(8'h10, 32'h200);
      repeat (100) @(posedge clk);
      `CHK(lk, 1'b0)
      wr(8'h10, 32'h2ff);
      rst_req <= 1;
      repeat (6) @(posedge clk);
      `CHK({lk, oc}, 6'h00)
      rd(8'h14);
      `CHK(d, 32'h2000_0000)
      rst_req <= 0;
      repeat (300) @(posedge clk);
      `CHK(lk, 1'b1)
      final_report();
   end
endmodule : plls_synth_test
